// >>> core/pfs_port_mux.sv
// Operation
// [RL1] alternate function disconnects other pin functions
// [RL2] data register reads pin level always (here port 2 has no pad inputs and reads back its data register)
// [RL3] reset pin low holds system reset
// [RL4] reset pin high releases reset, execution starts
// [RL5] six output bits, one secondary each (here bit 2 has no secondary and its select bit is not writable)
// [RL6] bit0 slow clock, bit1 fast clock
// [RL7] ports 4, 8: secondary or tertiary per bit
// [RL8] ports A, B: secondary per bit
// [RL9] i2c on port8/portB bits 0,1
// [RL10] serial0 tertiary on port4/port8 bits 0-2
// [RL11] serial1 on port8 4-6, port4/A 0-2
// [RL12] uart transmits swap on port8 bits 3,7
// [RL13] software selector per pin, primary after reset
// [RL14] peripheral enable and data replace port values
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "pfs_defs.svh"

module pfs_port_mux (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // external reset pin and resulting system reset
  input wire logic EXT_RESET_PIN_N,
  output logic SYS_RESET_N,
  // register port
  input wire logic [`PFS_AW-1:0] ADDR,
  input wire logic [`PFS_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [`PFS_DW-1:0] RDATA,
  // output-only port
  output logic [`PFS_P2_W-1:0] P2_OUT,
  // port 4
  input wire logic [`PFS_BW-1:0] P4_IN,
  output logic [`PFS_BW-1:0] P4_OUT,
  output logic [`PFS_BW-1:0] P4_OE,
  // port 8
  input wire logic [`PFS_BW-1:0] P8_IN,
  output logic [`PFS_BW-1:0] P8_OUT,
  output logic [`PFS_BW-1:0] P8_OE,
  // port A
  input wire logic [`PFS_BW-1:0] PA_IN,
  output logic [`PFS_BW-1:0] PA_OUT,
  output logic [`PFS_BW-1:0] PA_OE,
  // port B
  input wire logic [`PFS_PB_W-1:0] PB_IN,
  output logic [`PFS_PB_W-1:0] PB_OUT,
  output logic [`PFS_PB_W-1:0] PB_OE,
  // peripherals
  input wire pfs_pkg::pfs_periph_out_s PERIPH_OUT,
  output pfs_pkg::pfs_periph_in_s PERIPH_IN
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [`PFS_DW-1:0] pfs_wmask(input logic [`PFS_PIDX_W-1:0] p,
                                                   input logic [1:0] k);
    logic [`PFS_DW-1:0] m;
    m = `PFS_M_NONE;
    unique case (k)
      `PFS_K_DATA: m = (p == `PFS_P2) ? `PFS_M_P2 : (p == `PFS_PB) ? `PFS_M_PB : `PFS_M_ALL;
      `PFS_K_DIR: m = (p == `PFS_P2) ? `PFS_M_NONE : (p == `PFS_PB) ? `PFS_M_PB : `PFS_M_ALL;
      `PFS_K_SEC: begin
        unique case (p)
          `PFS_P2: m = `PFS_M_P2_SEC; // [RL5]
          `PFS_P4: m = `PFS_M_P4_SEC; // [RL7]
          `PFS_P8: m = `PFS_M_P8_SEC; // [RL7]
          `PFS_PA: m = `PFS_M_PA_SEC; // [RL8]
          `PFS_PB: m = `PFS_M_PB_SEC; // [RL8]
          default: m = `PFS_M_NONE;
        endcase
      end
      `PFS_K_TER: begin
        if (p == `PFS_P4) begin
          m = `PFS_M_P4_TER; // [RL7]
        end else if (p == `PFS_P8) begin
          m = `PFS_M_P8_TER; // [RL7]
        end
      end
    endcase
    return m;
  endfunction : pfs_wmask

  // tertiary wins when both selects of a bit are set
  function automatic pfs_pkg::pfs_fn_e pfs_fn(input logic sec, input logic ter);
    pfs_pkg::pfs_fn_e f;
    f = ter ? pfs_pkg::PFS_FN_TER : (sec ? pfs_pkg::PFS_FN_SEC : pfs_pkg::PFS_FN_PRI);
    return f;
  endfunction : pfs_fn

  // returns {oe, out} for one 8-bit port
  function automatic logic [2*`PFS_BW-1:0] pfs_mux(
    input logic [`PFS_BW-1:0] sec, input logic [`PFS_BW-1:0] ter,
    input logic [`PFS_BW-1:0] dat, input logic [`PFS_BW-1:0] dir,
    input logic [`PFS_BW-1:0] so, input logic [`PFS_BW-1:0] se,
    input logic [`PFS_BW-1:0] to, input logic [`PFS_BW-1:0] te);
    logic [`PFS_BW-1:0] o;
    logic [`PFS_BW-1:0] e;
    o = '0;
    e = '0;
    for (int i = 0; i < `PFS_BW; i++) begin
      unique case (pfs_fn(sec[i], ter[i]))
        pfs_pkg::PFS_FN_PRI: begin
          o[i] = dat[i];
          e[i] = dir[i];
        end
        pfs_pkg::PFS_FN_SEC: begin
          o[i] = so[i]; // [RL1] [RL14]
          e[i] = se[i];
        end
        pfs_pkg::PFS_FN_TER: begin
          o[i] = to[i]; // [RL1] [RL14]
          e[i] = te[i];
        end
      endcase
    end
    return {e, o};
  endfunction : pfs_mux

  // input to a peripheral from up to three candidate pins
  function automatic logic pfs_pick(input logic [2:0] lv, input logic [2:0] en,
                                    input logic idle);
    return (|en) ? |(lv & en) : idle;
  endfunction : pfs_pick

  // ----------------------------------------
  // reset and pad synchronisers
  // ----------------------------------------
  logic sys_rst_n;
  logic blk_reset_n;
  logic [`PFS_BW-1:0] p4_lv;
  logic [`PFS_BW-1:0] p8_lv;
  logic [`PFS_BW-1:0] pa_lv;
  logic [`PFS_PB_W-1:0] pb_lv;

  pfs_reset_ctl u_reset_ctl (
    .clk(CLK),
    .reset_n(RESET_N),
    .pin_n(EXT_RESET_PIN_N),
    .sys_reset_n(sys_rst_n)
  );

  assign SYS_RESET_N = sys_rst_n;
  // registers reinitialise while the system reset is held
  assign blk_reset_n = RESET_N & sys_rst_n; // [RL3]

  pfs_sync #(.W(3*`PFS_BW+`PFS_PB_W)) u_pad_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .d({P4_IN, P8_IN, PA_IN, PB_IN}),
    .q({p4_lv, p8_lv, pa_lv, pb_lv})
  );

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [`PFS_DW-1:0] dat [`PFS_NPORT];
  logic [`PFS_DW-1:0] dir [`PFS_NPORT];
  logic [`PFS_DW-1:0] sec [`PFS_NPORT];
  logic [`PFS_DW-1:0] ter [`PFS_NPORT];
  logic [`PFS_DW-1:0] next_dat [`PFS_NPORT];
  logic [`PFS_DW-1:0] next_dir [`PFS_NPORT];
  logic [`PFS_DW-1:0] next_sec [`PFS_NPORT];
  logic [`PFS_DW-1:0] next_ter [`PFS_NPORT];
  logic [`PFS_DW-1:0] next_rdata;
  logic [`PFS_PIDX_W-1:0] a_idx;
  logic [1:0] a_kind;
  logic [`PFS_DW-1:0] pin_lv;
  logic [`PFS_DW-1:0] wm;

  assign a_idx = ADDR[`PFS_IDX_HI:`PFS_IDX_LO];
  assign a_kind = ADDR[`PFS_KIND_HI:`PFS_KIND_LO];

  always_comb begin
    next_dat = dat;
    next_dir = dir;
    next_sec = sec;
    next_ter = ter;
    next_rdata = `PFS_RST_RDATA;
    wm = pfs_wmask(a_idx, a_kind);
    unique case (a_idx)
      `PFS_P4: pin_lv = p4_lv;
      `PFS_P8: pin_lv = p8_lv;
      `PFS_PA: pin_lv = pa_lv;
      `PFS_PB: pin_lv = {1'b0, pb_lv};
      default: pin_lv = dat[`PFS_P2];
    endcase
    if (WR && a_idx < `PFS_NPORT) begin
      unique case (a_kind)
        `PFS_K_DATA: next_dat[a_idx] = WDATA & wm;
        `PFS_K_DIR: next_dir[a_idx] = WDATA & wm;
        `PFS_K_SEC: next_sec[a_idx] = WDATA & wm; // [RL13]
        `PFS_K_TER: next_ter[a_idx] = WDATA & wm; // [RL13]
      endcase
    end
    if (RD && a_idx < `PFS_NPORT) begin
      unique case (a_kind)
        `PFS_K_DATA: next_rdata = pin_lv; // [RL2]
        `PFS_K_DIR: next_rdata = dir[a_idx];
        `PFS_K_SEC: next_rdata = sec[a_idx];
        `PFS_K_TER: next_rdata = ter[a_idx];
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!blk_reset_n) begin
      for (int p = 0; p < `PFS_NPORT; p++) begin
        dat[p] <= `PFS_RST_REG;
        dir[p] <= `PFS_RST_REG;
        sec[p] <= `PFS_RST_REG; // [RL13]
        ter[p] <= `PFS_RST_REG; // [RL13]
      end
      RDATA <= `PFS_RST_RDATA;
    end else begin
      dat <= next_dat;
      dir <= next_dir;
      sec <= next_sec;
      ter <= next_ter;
      RDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // alternate function wiring
  // ----------------------------------------
  pfs_pkg::pfs_periph_out_s po;
  logic [`PFS_BW-1:0] p2_so;
  logic [`PFS_BW-1:0] p4_so, p4_se, p4_to, p4_te;
  logic [`PFS_BW-1:0] p8_so, p8_se, p8_to, p8_te;
  logic [`PFS_BW-1:0] pa_so, pa_se;
  logic [`PFS_BW-1:0] pb_so, pb_se;

  assign po = PERIPH_OUT;
  assign p2_so = {2'b00, po.pulse_out, 1'b0, po.fast_clock_out, po.slow_clock_out}; // [RL6]
  assign p4_so = {5'h00, po.serial1_data_out, po.serial1_clock_o, 1'b0}; // [RL11]
  assign p4_se = {5'h00, 1'b1, po.serial1_clock_oe, 1'b0};
  assign p4_to = {5'h00, po.serial0_data_out, po.serial0_clock_o, 1'b0}; // [RL10]
  assign p4_te = {5'h00, 1'b1, po.serial0_clock_oe, 1'b0};
  // i2c pins are open drain: drive low only
  assign p8_so = {po.uart_a_transmit, 3'b000, po.uart_b_transmit, 3'b000}; // [RL12]
  assign p8_se = {2'b10, 2'b00, 2'b10, po.i2c_clock_pull_low, po.i2c_data_pull_low}; // [RL9]
  assign p8_to = {po.uart_b_transmit, po.serial1_data_out, po.serial1_clock_o, 1'b0,
                  po.uart_a_transmit, po.serial0_data_out, po.serial0_clock_o, 1'b0}; // [RL12]
  assign p8_te = {2'b11, po.serial1_clock_oe, 1'b0,
                  2'b11, po.serial0_clock_oe, 1'b0}; // [RL10] [RL11]
  assign pa_so = {4'h0, po.pulse_out[0], po.serial1_data_out, po.serial1_clock_o, 1'b0};
  assign pa_se = {4'h0, 2'b11, po.serial1_clock_oe, 1'b0}; // [RL11]
  assign pb_so = {5'h00, po.pulse_out[1], 2'b00};
  assign pb_se = {5'h00, 1'b1, po.i2c_clock_pull_low, po.i2c_data_pull_low}; // [RL9]

  // ----------------------------------------
  // pad and peripheral outputs
  // ----------------------------------------
  logic [`PFS_BW-1:0] s4, s8, t4, t8;
  logic [2*`PFS_BW-1:0] m2, m4, m8, ma, mb;
  logic [`PFS_P2_W-1:0] next_p2_out;
  pfs_pkg::pfs_periph_in_s next_periph_in;

  // secondary select is ignored on a bit whose tertiary is set
  assign s4 = sec[`PFS_P4] & ~ter[`PFS_P4];
  assign s8 = sec[`PFS_P8] & ~ter[`PFS_P8];
  assign t4 = ter[`PFS_P4];
  assign t8 = ter[`PFS_P8];

  always_comb begin
    m2 = pfs_mux(sec[`PFS_P2], '0, dat[`PFS_P2], `PFS_M_ALL, p2_so, `PFS_M_ALL, '0, '0); // [RL5]
    m4 = pfs_mux(s4, t4, dat[`PFS_P4], dir[`PFS_P4], p4_so, p4_se, p4_to, p4_te); // [RL7]
    m8 = pfs_mux(s8, t8, dat[`PFS_P8], dir[`PFS_P8], p8_so, p8_se, p8_to, p8_te); // [RL7]
    ma = pfs_mux(sec[`PFS_PA], '0, dat[`PFS_PA], dir[`PFS_PA], pa_so, pa_se, '0, '0); // [RL8]
    mb = pfs_mux(sec[`PFS_PB], '0, dat[`PFS_PB], dir[`PFS_PB], pb_so, pb_se, '0, '0); // [RL8]
    next_p2_out = m2[`PFS_P2_W-1:0];
    next_periph_in.serial0_data_in = pfs_pick({1'b0, p8_lv[0], p4_lv[0]},
                                              {1'b0, t8[0], t4[0]}, 1'b0); // [RL10]
    next_periph_in.serial0_clock_in = pfs_pick({1'b0, p8_lv[1], p4_lv[1]},
                                               {1'b0, t8[1], t4[1]}, 1'b0); // [RL10]
    next_periph_in.serial1_data_in = pfs_pick({pa_lv[0], p8_lv[4], p4_lv[0]},
                                              {sec[`PFS_PA][0], t8[4], s4[0]}, 1'b0); // [RL11]
    next_periph_in.serial1_clock_in = pfs_pick({pa_lv[1], p8_lv[5], p4_lv[1]},
                                               {sec[`PFS_PA][1], t8[5], s4[1]}, 1'b0); // [RL11]
    next_periph_in.uart_a_receive = pfs_pick({2'b00, p8_lv[6]}, {2'b00, s8[6]}, 1'b1);
    next_periph_in.uart_b_receive = pfs_pick({2'b00, p8_lv[2]}, {2'b00, s8[2]}, 1'b1);
    next_periph_in.i2c_data_in = pfs_pick({1'b0, pb_lv[0], p8_lv[0]},
                                          {1'b0, sec[`PFS_PB][0], s8[0]}, 1'b1); // [RL9]
    next_periph_in.i2c_clock_in = pfs_pick({1'b0, pb_lv[1], p8_lv[1]},
                                           {1'b0, sec[`PFS_PB][1], s8[1]}, 1'b1); // [RL9]
    // interrupt inputs are the primary function and always see the pad
    next_periph_in.ext_int = p8_lv;
  end

  // one register stage keeps every pad output glitch free; clocks out are sampled
  always_ff @(posedge CLK) begin
    if (!blk_reset_n) begin
      P2_OUT <= '0;
      P4_OUT <= '0;
      P4_OE <= '0;
      P8_OUT <= '0;
      P8_OE <= '0;
      PA_OUT <= '0;
      PA_OE <= '0;
      PB_OUT <= '0;
      PB_OE <= '0;
      PERIPH_IN <= '0;
    end else begin
      P2_OUT <= next_p2_out;
      P4_OUT <= m4[`PFS_BW-1:0];
      P4_OE <= m4[2*`PFS_BW-1:`PFS_BW];
      P8_OUT <= m8[`PFS_BW-1:0];
      P8_OE <= m8[2*`PFS_BW-1:`PFS_BW];
      PA_OUT <= ma[`PFS_BW-1:0];
      PA_OE <= ma[2*`PFS_BW-1:`PFS_BW];
      PB_OUT <= mb[`PFS_PB_W-1:0];
      PB_OE <= mb[`PFS_BW+`PFS_PB_W-1:`PFS_BW];
      PERIPH_IN <= next_periph_in;
    end
  end

endmodule : pfs_port_mux

// >>> core/pfs_defs.svh
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define PFS_AW 5
`define PFS_DW 8
`define PFS_NPORT 5
`define PFS_PIDX_W 3
`define PFS_BW 8
`define PFS_PB_W 7
`define PFS_P2_W 6

// ----------------------------------------
// address split: port index in [4:2], register kind in [1:0]
// ----------------------------------------
`define PFS_IDX_HI 4
`define PFS_IDX_LO 2
`define PFS_KIND_HI 1
`define PFS_KIND_LO 0

// ----------------------------------------
// port indices (byte address = index * 4)
// ----------------------------------------
`define PFS_P2 3'h0
`define PFS_P4 3'h1
`define PFS_P8 3'h2
`define PFS_PA 3'h3
`define PFS_PB 3'h4

// ----------------------------------------
// register kinds within a port
// ----------------------------------------
`define PFS_K_DATA 2'h0
`define PFS_K_DIR 2'h1
`define PFS_K_SEC 2'h2
`define PFS_K_TER 2'h3

// ----------------------------------------
// writable bit masks
// ----------------------------------------
`define PFS_M_NONE 8'h00
`define PFS_M_ALL 8'hFF
`define PFS_M_P2 8'h3F
`define PFS_M_PB 8'h7F
`define PFS_M_P2_SEC 8'h3B
`define PFS_M_P4_SEC 8'h07
`define PFS_M_P4_TER 8'h07
`define PFS_M_P8_SEC 8'hCF
`define PFS_M_P8_TER 8'hFF
`define PFS_M_PA_SEC 8'h0F
`define PFS_M_PB_SEC 8'h07

// ----------------------------------------
// reset values
// ----------------------------------------
`define PFS_RST_REG 8'h00
`define PFS_RST_RDATA 8'h00

`endif

// >>> core/pfs_pkg.sv
package pfs_pkg;

  // ----------------------------------------
  // pin function
  // ----------------------------------------
  typedef enum logic [1:0] {
    PFS_FN_PRI,
    PFS_FN_SEC,
    PFS_FN_TER
  } pfs_fn_e;

  // ----------------------------------------
  // peripheral drive towards the pads
  // ----------------------------------------
  typedef struct packed {
    logic slow_clock_out;
    logic fast_clock_out;
    logic [2:0] pulse_out;
    logic serial0_clock_o;
    logic serial0_clock_oe;
    logic serial0_data_out;
    logic serial1_clock_o;
    logic serial1_clock_oe;
    logic serial1_data_out;
    logic uart_a_transmit;
    logic uart_b_transmit;
    logic i2c_data_pull_low;
    logic i2c_clock_pull_low;
  } pfs_periph_out_s;

  // ----------------------------------------
  // pad levels towards the peripherals
  // ----------------------------------------
  typedef struct packed {
    logic serial0_data_in;
    logic serial0_clock_in;
    logic serial1_data_in;
    logic serial1_clock_in;
    logic uart_a_receive;
    logic uart_b_receive;
    logic i2c_data_in;
    logic i2c_clock_in;
    logic [7:0] ext_int;
  } pfs_periph_in_s;

endpackage : pfs_pkg

// >>> core/pfs_sync.sv
`timescale 1ns/100ps

module pfs_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule : pfs_sync

// >>> core/pfs_reset_ctl.sv
`timescale 1ns/100ps

module pfs_reset_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // external reset pin, asynchronous to clk
  input wire logic pin_n,
  // system reset, active low
  output logic sys_reset_n
);

  logic pin_sync_n;
  logic next_sys_reset_n;

  pfs_sync #(.W(1), .RST_VAL(1'b0)) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(pin_n),
    .q(pin_sync_n)
  );

  always_comb begin
    next_sys_reset_n = pin_sync_n; // [RL3] [RL4]
  end

  // pin low holds reset, pin high releases it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_reset_n <= 1'b0;
    end else begin
      sys_reset_n <= next_sys_reset_n;
    end
  end

endmodule : pfs_reset_ctl

// >>> verif/pfs_pad_model.sv
`timescale 1ns/100ps

module pfs_pad_model #(
  parameter int W = 8
) (
  // design side
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] dout,
  // board side
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  // resolved pad level
  output logic [W-1:0] pad
);
  // ----
  // board pull-ups keep released pads high, two drivers give contention
  // ----
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i] && ext_en[i])
        pad[i] = 1'hx;
      else if (oe[i])
        pad[i] = dout[i];
      else if (ext_en[i])
        pad[i] = ext_val[i];
      else
        pad[i] = 1'h1;
    end
  end
endmodule : pfs_pad_model

// >>> verif/pfs_port_mux_props.sv
`timescale 1ns/100ps

module pfs_port_mux_chk (
  // clock and resets
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic EXT_RESET_PIN_N,
  input wire logic SYS_RESET_N,
  // register port
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // pads
  input wire logic [5:0] P2_OUT,
  input wire logic [7:0] P4_OE,
  input wire logic [7:0] P8_IN,
  input wire logic [7:0] P8_OUT,
  input wire logic [7:0] P8_OE,
  input wire logic [7:0] PA_OE,
  input wire logic [6:0] PB_OE,
  // peripherals
  input wire pfs_pkg::pfs_periph_out_s PERIPH_OUT,
  input wire pfs_pkg::pfs_periph_in_s PERIPH_IN
);
  // ----
  // shadow select bits, cleared by either reset like the design's own
  // ----
  logic run;
  logic [7:0] p2_sec;
  logic [7:0] p8_sec;
  logic [7:0] p8_ter;
  logic [7:0] next_p2_sec;
  logic [7:0] next_p8_sec;
  logic [7:0] next_p8_ter;
  assign run = RESET_N && SYS_RESET_N;
  always_comb begin
    next_p2_sec = p2_sec;
    next_p8_sec = p8_sec;
    next_p8_ter = p8_ter;
    if (WR && ADDR == 5'h02)
      next_p2_sec = WDATA & 8'h3B;
    if (WR && ADDR == 5'h0A)
      next_p8_sec = WDATA & 8'hCF;
    if (WR && ADDR == 5'h0B)
      next_p8_ter = WDATA;
  end
  always_ff @(posedge CLK) begin
    if (!run) begin
      p2_sec <= 8'h00;
      p8_sec <= 8'h00;
      p8_ter <= 8'h00;
    end else begin
      p2_sec <= next_p2_sec;
      p8_sec <= next_p8_sec;
      p8_ter <= next_p8_ter;
    end
  end
  // ----
  // properties
  // ----
  property p_ext_hold;
    @(posedge CLK) disable iff (!RESET_N) (!EXT_RESET_PIN_N) [*4] |-> !SYS_RESET_N;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("pin low, no reset");
  property p_ext_free;
    @(posedge CLK) disable iff (!RESET_N) EXT_RESET_PIN_N [*5] |-> SYS_RESET_N;
  endproperty
  a_ext_free: assert property (p_ext_free) else $error("reset not released");
  property p_rst_quiet;
    @(posedge CLK) disable iff (!RESET_N) (!SYS_RESET_N) [*3] |->
      (P4_OE | P8_OE | PA_OE) == 8'h00 && PB_OE == 7'h00 && P2_OUT == 6'h00;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("pads live in reset");
  property p_clk_route;
    @(posedge CLK) disable iff (!run) $past(p2_sec[1:0]) == 2'h3 |-> P2_OUT[1:0] ==
      {$past(PERIPH_OUT.fast_clock_out), $past(PERIPH_OUT.slow_clock_out)};
  endproperty
  a_clk_route: assert property (p_clk_route) else $error("clock outs wrong");
  property p_uart_ter;
    @(posedge CLK) disable iff (!run) $past(p8_ter[3]) |->
      P8_OE[3] && P8_OUT[3] == $past(PERIPH_OUT.uart_a_transmit);
  endproperty
  a_uart_ter: assert property (p_uart_ter) else $error("bit3 tertiary wrong");
  property p_uart_sec;
    @(posedge CLK) disable iff (!run) $past(p8_sec[7]) && !$past(p8_ter[7]) |->
      P8_OE[7] && P8_OUT[7] == $past(PERIPH_OUT.uart_a_transmit);
  endproperty
  a_uart_sec: assert property (p_uart_sec) else $error("bit7 secondary wrong");
  property p_i2c_low;
    @(posedge CLK) disable iff (!run) $past(p8_sec[0]) && !$past(p8_ter[0]) &&
      $past(PERIPH_OUT.i2c_data_pull_low) |-> P8_OE[0] && !P8_OUT[0];
  endproperty
  a_i2c_low: assert property (p_i2c_low) else $error("data line not pulled");
  property p_read_pin;
    @(posedge CLK) disable iff (!run) RD && ADDR == 5'h08 |=> RDATA == $past(P8_IN, 3);
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("pin read wrong");
  property p_ext_int;
    @(posedge CLK) disable iff (!run) $past(run, 4) |-> PERIPH_IN.ext_int == $past(P8_IN, 3);
  endproperty
  a_ext_int: assert property (p_ext_int) else $error("interrupt level wrong");
endmodule : pfs_port_mux_chk

bind pfs_port_mux pfs_port_mux_chk u_chk (
  .CLK(CLK), .RESET_N(RESET_N), .EXT_RESET_PIN_N(EXT_RESET_PIN_N),
  .SYS_RESET_N(SYS_RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .P2_OUT(P2_OUT), .P4_OE(P4_OE), .P8_IN(P8_IN), .P8_OUT(P8_OUT),
  .P8_OE(P8_OE), .PA_OE(PA_OE), .PB_OE(PB_OE), .PERIPH_OUT(PERIPH_OUT),
  .PERIPH_IN(PERIPH_IN)
);

// >>> verif/testbench.sv
`timescale 1ns/100ps

module testbench;
  // ----
  // design pins and board drive
  // ----
  logic CLK, RESET_N, EXT_RESET_PIN_N, SYS_RESET_N, WR, RD;
  logic [4:0] ADDR;
  logic [7:0] WDATA, RDATA, d, b4_en, b4_v, b8_en, b8_v, ba_en, ba_v;
  logic [5:0] P2_OUT;
  logic [7:0] P4_IN, P4_OUT, P4_OE, P8_IN, P8_OUT, P8_OE, PA_IN, PA_OUT, PA_OE;
  logic [6:0] PB_IN, PB_OUT, PB_OE;
  pfs_pkg::pfs_periph_out_s PERIPH_OUT;
  pfs_pkg::pfs_periph_in_s PERIPH_IN;
  int miscompares, n_compared;

  pfs_port_mux uut (
    .CLK(CLK), .RESET_N(RESET_N), .EXT_RESET_PIN_N(EXT_RESET_PIN_N),
    .SYS_RESET_N(SYS_RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .P2_OUT(P2_OUT), .P4_IN(P4_IN), .P4_OUT(P4_OUT), .P4_OE(P4_OE),
    .P8_IN(P8_IN), .P8_OUT(P8_OUT), .P8_OE(P8_OE), .PA_IN(PA_IN), .PA_OUT(PA_OUT),
    .PA_OE(PA_OE), .PB_IN(PB_IN), .PB_OUT(PB_OUT), .PB_OE(PB_OE),
    .PERIPH_OUT(PERIPH_OUT), .PERIPH_IN(PERIPH_IN)
  );
  pfs_pad_model #(.W(8)) u_p4 (.oe(P4_OE), .dout(P4_OUT), .ext_en(b4_en),
    .ext_val(b4_v), .pad(P4_IN));
  pfs_pad_model #(.W(8)) u_p8 (.oe(P8_OE), .dout(P8_OUT), .ext_en(b8_en),
    .ext_val(b8_v), .pad(P8_IN));
  pfs_pad_model #(.W(8)) u_pa (.oe(PA_OE), .dout(PA_OUT), .ext_en(ba_en),
    .ext_val(ba_v), .pad(PA_IN));
  pfs_pad_model #(.W(7)) u_pb (.oe(PB_OE), .dout(PB_OUT), .ext_en(7'h00),
    .ext_val(7'h00), .pad(PB_IN));

  // ----
  // shared tasks
  // ----
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'h1;
    @(posedge CLK);
    WR <= 1'h0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge CLK);
    RD <= 1'h0;
    #1;
    d = RDATA;
  endtask : rd
  // pads lag the select by one cycle and inputs by three more
  task automatic look;
    repeat (6) @(posedge CLK);
    #1;
  endtask : look
  task automatic wait_sys;
    for (int i = 0; i < 20 && SYS_RESET_N !== 1'h1; i++)
      @(posedge CLK);
    chk("system reset", {7'h00, SYS_RESET_N}, 8'h01);
  endtask : wait_sys
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    logic [7:0] msk [0:4][1:3] = '{'{8'h00, 8'h3B, 8'h00}, '{8'hFF, 8'h07, 8'h07},
      '{8'hFF, 8'hCF, 8'hFF}, '{8'hFF, 8'h0F, 8'h00}, '{8'h7F, 8'h07, 8'h00}};
    chk("p8 oe", P8_OE, 8'h00);
    for (int p = 0; p < 5; p++) begin
      for (int k = 1; k < 4; k++) begin
        rd({p[2:0], k[1:0]});
        chk("reset value", d, 8'h00);
        wr({p[2:0], k[1:0]}, 8'hFF);
        rd({p[2:0], k[1:0]});
        chk("writable", d, msk[p][k]);
        wr({p[2:0], k[1:0]}, 8'h00);
      end
    end
    wr(5'h00, 8'hFF);
    rd(5'h00);
    chk("p2 data", d, 8'h3F);
    wr(5'h14, 8'hFF);
    rd(5'h14);
    chk("unmapped", d, 8'h00);
    chk("p2 out", {2'h0, P2_OUT}, 8'h3F);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_p2;
    @(posedge CLK);
    PERIPH_OUT.fast_clock_out <= 1'h1;
    PERIPH_OUT.pulse_out <= 3'h2;
    wr(5'h02, 8'h03);
    look;
    chk("p2 clocks", {2'h0, P2_OUT}, 8'h3E);
    wr(5'h02, 8'h3B);
    look;
    chk("p2 alternates", {2'h0, P2_OUT}, 8'h16);
    wr(5'h02, 8'h00);
    look;
    chk("p2 port again", {2'h0, P2_OUT}, 8'h3F);
    $display("t_p2 done");
  endtask : t_p2
  task automatic t_p8;
    wr(5'h09, 8'hFF);
    wr(5'h08, 8'hFF);
    @(posedge CLK);
    PERIPH_OUT.uart_b_transmit <= 1'h1;
    wr(5'h0A, 8'h80);
    wr(5'h0B, 8'h08);
    look;
    chk("p8 oe", P8_OE, 8'hFF);
    chk("p8 uart a", P8_OUT, 8'h77);
    wr(5'h08, 8'h00);
    wr(5'h0A, 8'h08);
    wr(5'h0B, 8'h80);
    look;
    chk("p8 uart b", P8_OUT, 8'h88);
    wr(5'h0A, 8'h00);
    wr(5'h0B, 8'h00);
    $display("t_p8 done");
  endtask : t_p8
  task automatic t_i2c;
    wr(5'h08, 8'hFF);
    wr(5'h11, 8'h7F);
    wr(5'h10, 8'h7F);
    @(posedge CLK);
    PERIPH_OUT.i2c_data_pull_low <= 1'h1;
    wr(5'h0A, 8'h03);
    wr(5'h12, 8'h03);
    look;
    chk("p8 i2c oe", {6'h00, P8_OE[1:0]}, 8'h01);
    chk("p8 i2c low", {7'h00, P8_OUT[0]}, 8'h00);
    chk("pb i2c oe", {6'h00, PB_OE[1:0]}, 8'h01);
    chk("pb i2c low", {7'h00, PB_OUT[0]}, 8'h00);
    chk("i2c in", {6'h00, PERIPH_IN.i2c_data_in, PERIPH_IN.i2c_clock_in}, 8'h01);
    rd(5'h08);
    chk("p8 levels", d, 8'hFE);
    wr(5'h0A, 8'h00);
    wr(5'h12, 8'h00);
    $display("t_i2c done");
  endtask : t_i2c
  task automatic t_ser;
    wr(5'h05, 8'hFF);
    wr(5'h04, 8'h00);
    wr(5'h06, 8'h07);
    @(posedge CLK);
    b4_en <= 8'h01;
    b4_v <= 8'h01;
    PERIPH_OUT.serial1_data_out <= 1'h1;
    look;
    chk("p4 oe", P4_OE, 8'hFC);
    chk("p4 s1 out", {7'h00, P4_OUT[2]}, 8'h01);
    chk("s1 in", {7'h00, PERIPH_IN.serial1_data_in}, 8'h01);
    rd(5'h04);
    chk("p4 levels", d, 8'h07);
    wr(5'h07, 8'h07);
    look;
    chk("p4 s0 out", {7'h00, P4_OUT[2]}, 8'h00);
    chk("s0 in", {7'h00, PERIPH_IN.serial0_data_in}, 8'h01);
    @(posedge CLK);
    b4_en <= 8'h00;
    wr(5'h06, 8'h00);
    wr(5'h07, 8'h00);
    $display("t_ser done");
  endtask : t_ser
  task automatic t_alt;
    wr(5'h0C, 8'hFF);
    wr(5'h0D, 8'hFF);
    wr(5'h0E, 8'h0F);
    wr(5'h0A, 8'h44);
    @(posedge CLK);
    ba_en <= 8'h01;
    ba_v <= 8'h01;
    b8_en <= 8'h44;
    b8_v <= 8'h04;
    look;
    chk("pa oe", PA_OE, 8'hFC);
    chk("pa out", PA_OUT, 8'hF4);
    chk("alt in", {5'h00, PERIPH_IN.serial1_data_in, PERIPH_IN.uart_a_receive,
      PERIPH_IN.uart_b_receive}, 8'h05);
    @(posedge CLK);
    ba_en <= 8'h00;
    b8_en <= 8'h00;
    $display("t_alt done");
  endtask : t_alt
  task automatic t_xrst;
    wr(5'h0A, 8'h80);
    @(posedge CLK);
    EXT_RESET_PIN_N <= 1'h0;
    repeat (6) @(posedge CLK);
    #1;
    chk("sys reset low", {7'h00, SYS_RESET_N}, 8'h00);
    chk("p8 oe cleared", P8_OE, 8'h00);
    @(posedge CLK);
    EXT_RESET_PIN_N <= 1'h1;
    wait_sys;
    rd(5'h0A);
    chk("select cleared", d, 8'h00);
    $display("t_xrst done");
  endtask : t_xrst

  // ----
  // clock, sequence and watchdog
  // ----
  initial begin
    CLK = 1'h0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    miscompares = 0;
    n_compared = 0;
    RESET_N = 1'h0;
    EXT_RESET_PIN_N = 1'h1;
    ADDR = 5'h00;
    WDATA = 8'h00;
    WR = 1'h0;
    RD = 1'h0;
    PERIPH_OUT = '0;
    b4_en = 8'h00;
    b4_v = 8'h00;
    b8_en = 8'h00;
    b8_v = 8'h00;
    ba_en = 8'h00;
    ba_v = 8'h00;
    repeat (12) @(posedge CLK);
    RESET_N <= 1'h1;
    wait_sys;
    t_regs;
    t_p2;
    t_p8;
    t_i2c;
    t_ser;
    t_alt;
    t_xrst;
    close_out;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    miscompares++;
    close_out;
  end
endmodule : testbench
